// ### logic/tmcm_mailbox.sv
/*
  Transducer command mailbox: AHB-Lite register slave, command sequencer
  driving a request/reply link to the serial transducer engine, reply
  timeout, diagnostic latches and a level interrupt.
  Assumes one clock, a single AHB-Lite master and a link engine that
  offers each reply as a one-cycle pulse.
*/
module tmcm_mailbox
  import tmcm_pkg::*;
#(
  parameter int TIMEOUT_CYC = REPLY_TIMEOUT_CYC
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  output logic xdcr_req_valid,
  input wire logic xdcr_req_ready,
  output logic xdcr_req_op,
  output logic [CHAN_W-1:0] xdcr_req_chan,
  input wire logic xdcr_rsp_valid,
  input wire logic xdcr_rsp_parity_err,
  input wire logic xdcr_rsp_addr_err,
  input wire logic xdcr_rsp_code_err,
  input wire logic xdcr_rsp_bit_fail,
  input wire logic xdcr_rsp_invalid_input,
  input wire logic xdcr_rsp_internal_fail
);

  tmcm_state_t state_r;
  logic wr_pend_r;
  logic addr_ok_r;
  logic [ADDR_W-1:0] addr_r;
  logic [31:0] cmd_r;
  logic [31:0] resp_r;
  logic [CHAN_W-1:0] tgt_r;
  logic [CHAN_W-1:0] tgt_lat_r;
  logic [CHAN_W-1:0] idx_r;
  logic [NUM_CHAN-1:0] chan_en_r;
  logic [NUM_CHAN-1:0] diag_bit_r;
  logic [NUM_CHAN-1:0] diag_inp_r;
  logic [NUM_CHAN-1:0] diag_int_r;
  logic [IRQ_W-1:0] irq_sts_r;
  logic [IRQ_W-1:0] irq_en_r;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic hold_d_r;
  logic wr_cmd;
  logic order_err;
  logic req_fire;
  logic tmo_exp;
  logic diag_rsp;
  logic [31:0] eval_code;
  logic eval_err;

  // Write strobe for one register in its data phase
  function automatic logic reg_wr(input logic [ADDR_W-1:0] off);
    return wr_pend_r && addr_ok_r && addr_r == off;
  endfunction

  // States in which a command is still being worked on
  function automatic logic is_busy(input tmcm_state_t s);
    return s != S_IDLE && s != S_HOLD;
  endfunction

  // Zero-wait slave: every transfer completes with OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase capture; only word transfers are expected
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      addr_ok_r <= 1'b0;
      addr_r <= '0;
    end else if (hready) begin
      wr_pend_r <= hsel && htrans[1] && hwrite;
      addr_ok_r <= hsel && htrans[1] && haddr[31:ADDR_W] == '0;
      addr_r <= haddr[ADDR_W-1:0];
    end
  end

  assign wr_cmd = reg_wr(OFF_CMD);
  assign order_err = wr_cmd && hwdata != CMD_IDLE && state_r != S_IDLE;

  // Command field; software owns it, hardware only reads it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_r <= CMD_IDLE;
    end else if (wr_cmd) begin
      cmd_r <= hwdata;
    end
  end

  // Target channel may change at any time; a command latches its copy
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tgt_r <= '0;
    end else if (reg_wr(OFF_TGT)) begin
      tgt_r <= hwdata[CHAN_W-1:0];
    end
  end

  // Channel enable and interrupt enable
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chan_en_r <= CHAN_EN_RST;
      irq_en_r <= '0;
    end else begin
      if (reg_wr(OFF_CHAN_EN)) begin
        chan_en_r <= hwdata[NUM_CHAN-1:0];
      end
      if (reg_wr(OFF_IRQ_EN)) begin
        irq_en_r <= hwdata[IRQ_W-1:0];
      end
    end
  end

  tmcm_reply_eval u_eval (
    .parity_err(xdcr_rsp_parity_err),
    .addr_err(xdcr_rsp_addr_err),
    .code_err(xdcr_rsp_code_err),
    .bit_fail(xdcr_rsp_bit_fail),
    .invalid_input(xdcr_rsp_invalid_input),
    .code(eval_code),
    .is_err(eval_err)
  );

  assign req_fire = xdcr_req_valid && xdcr_req_ready;
  assign diag_rsp = state_r == S_DIAG_WAIT && xdcr_rsp_valid;

  // Restarted per request, so a stale run never leaks into the next one
  tmcm_timeout #(
    .LIMIT(TIMEOUT_CYC)
  ) u_tmo (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(req_fire),
    .stop(xdcr_rsp_valid),
    .expired(tmo_exp)
  );

  // Command sequencer and response field
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= S_IDLE;
      resp_r <= RESP_IDLE;
      tgt_lat_r <= '0;
      idx_r <= '0;
    end else if (order_err) begin
      state_r <= S_HOLD;
      resp_r <= RESP_ORDER;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          if (cmd_r == CMD_RESET) begin
            state_r <= S_RST_TX;
            resp_r <= RESP_BUSY;
            tgt_lat_r <= tgt_r;
          end
        end
        S_RST_TX: begin
          if (xdcr_req_ready) begin
            idx_r <= '0;
            // Broadcast gets no reply, so go straight to the scan
            state_r <= (tgt_lat_r == CHAN_BCAST) ? S_SCAN : S_RST_WAIT;
          end
        end
        S_RST_WAIT: begin
          if (xdcr_rsp_valid || tmo_exp) begin
            state_r <= S_SCAN;
          end
        end
        S_SCAN: begin
          if (idx_r > CHAN_LAST) begin
            state_r <= S_HOLD;
            resp_r <= RESP_DONE;
          end else if (chan_en_r[idx_r]) begin
            state_r <= S_DIAG_TX;
          end else begin
            idx_r <= idx_r + 1'b1;
          end
        end
        S_DIAG_TX: begin
          if (xdcr_req_ready) begin
            state_r <= S_DIAG_WAIT;
          end
        end
        S_DIAG_WAIT: begin
          if (xdcr_rsp_valid) begin
            if (eval_err) begin
              state_r <= S_HOLD;
              resp_r <= eval_code;
            end else begin
              idx_r <= idx_r + 1'b1;
              state_r <= S_SCAN;
            end
          end else if (tmo_exp) begin
            state_r <= S_HOLD;
            resp_r <= RESP_TIMEOUT;
          end
        end
        S_HOLD: begin
          // Result stays until software puts the command back to idle
          if (cmd_r == CMD_IDLE) begin
            state_r <= S_IDLE;
            resp_r <= RESP_IDLE;
          end
        end
      endcase
    end
  end

  // Latched sensor diagnostics, refreshed by each re-read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      diag_bit_r <= '0;
      diag_inp_r <= '0;
      diag_int_r <= '0;
    end else if (diag_rsp) begin
      diag_bit_r[idx_r] <= xdcr_rsp_bit_fail;
      diag_inp_r[idx_r] <= xdcr_rsp_invalid_input;
      diag_int_r[idx_r] <= xdcr_rsp_internal_fail;
    end
  end

  // Link request: reset to the latched target, diag read to the scan index
  assign xdcr_req_valid = state_r == S_RST_TX || state_r == S_DIAG_TX;
  assign xdcr_req_op = (state_r == S_DIAG_TX) ? OP_DIAG : OP_RESET;
  assign xdcr_req_chan = (state_r == S_DIAG_TX) ? idx_r : tgt_lat_r;

  // Events fire on entry to the result state; set beats clear
  assign irq_set[IRQ_DONE] = state_r == S_HOLD && !hold_d_r;
  assign irq_set[IRQ_ERR] = state_r == S_HOLD && !hold_d_r && resp_r != RESP_DONE;
  assign irq_clr = reg_wr(OFF_IRQ_CLR) ? hwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hold_d_r <= 1'b0;
      irq_sts_r <= '0;
    end else begin
      hold_d_r <= state_r == S_HOLD;
      irq_sts_r <= (irq_sts_r & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_sts_r & irq_en_r);

  // Read mux; reserved words of the command area read zero
  always_comb begin
    unique case (addr_r)
      OFF_CMD: hrdata = resp_r;
      OFF_TGT: hrdata = 32'(tgt_r);
      OFF_IRQ_STS: hrdata = 32'(irq_sts_r);
      OFF_IRQ_EN: hrdata = 32'(irq_en_r);
      OFF_CHAN_EN: hrdata = 32'(chan_en_r);
      OFF_DIAG_BIT: hrdata = 32'(diag_bit_r);
      OFF_DIAG_INP: hrdata = 32'(diag_inp_r);
      OFF_DIAG_INT: hrdata = 32'(diag_int_r);
      default: hrdata = 32'h0000_0000;
    endcase
    if (!addr_ok_r) begin
      hrdata = 32'h0000_0000;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_busy_response: assert property (
    is_busy(state_r) |-> resp_r == RESP_BUSY)
    else $error("busy without processing response");

  chk_reset_start: assert property (
    state_r == S_IDLE && cmd_r == CMD_RESET && !order_err
    |=> resp_r == RESP_BUSY && xdcr_req_valid && xdcr_req_op == OP_RESET)
    else $error("reset command not started");

  chk_target_latch: assert property (
    $rose(xdcr_req_valid) && xdcr_req_op == OP_RESET |-> xdcr_req_chan == $past(tgt_r))
    else $error("reset sent to wrong channel");

  chk_bcast_skip: assert property (
    req_fire && xdcr_req_op == OP_RESET && xdcr_req_chan == CHAN_BCAST && !order_err
    |=> state_r == S_SCAN)
    else $error("broadcast reset waited for reply");

  chk_reset_no_err: assert property (
    state_r == S_RST_WAIT && xdcr_rsp_valid && !order_err |=> state_r == S_SCAN && resp_r == RESP_BUSY)
    else $error("reset reply produced error");

  chk_timeout_code: assert property (
    state_r == S_DIAG_WAIT && tmo_exp && !xdcr_rsp_valid && !order_err
    |=> resp_r == RESP_TIMEOUT && state_r == S_HOLD)
    else $error("timeout not reported");

  chk_reply_err: assert property (
    diag_rsp && (xdcr_rsp_parity_err || xdcr_rsp_addr_err || xdcr_rsp_code_err) && !order_err
    |=> resp_r == RESP_RSP_ERR)
    else $error("reply fault not reported");

  chk_bit_fail: assert property (
    diag_rsp && !(xdcr_rsp_parity_err || xdcr_rsp_addr_err || xdcr_rsp_code_err)
    && (xdcr_rsp_bit_fail || xdcr_rsp_invalid_input) && !order_err
    |=> state_r == S_HOLD && resp_r == ($past(xdcr_rsp_bit_fail) ? RESP_BIT_FAIL : RESP_INP_FAIL))
    else $error("sensor failure code wrong");

  chk_order_code: assert property (
    order_err |=> resp_r == RESP_ORDER && state_r == S_HOLD)
    else $error("order error not reported");

  chk_diag_reread: assert property (
    state_r == S_SCAN && idx_r <= CHAN_LAST && chan_en_r[idx_r] && !order_err
    |=> xdcr_req_valid && xdcr_req_op == OP_DIAG && xdcr_req_chan == $past(idx_r))
    else $error("enabled channel not re-read");

  chk_idle_return: assert property (
    state_r == S_HOLD && cmd_r == CMD_IDLE && !order_err |=> resp_r == RESP_IDLE ##1 !irq_set[IRQ_DONE])
    else $error("idle response not restored");

  cov_bcast_done: cover property (
    req_fire && xdcr_req_chan == CHAN_BCAST ##[1:200] resp_r == RESP_DONE);
  cov_timeout: cover property (state_r == S_DIAG_WAIT ##1 resp_r == RESP_TIMEOUT);
  cov_order_err: cover property (is_busy(state_r) && order_err);
  cov_bit_fail: cover property (resp_r == RESP_BIT_FAIL);

endmodule // tmcm_mailbox

// ### logic/tmcm_pkg.sv
/*
  Shared constants for the transducer command mailbox: register map,
  command and response codes, channel layout, interrupt bits, timing.
  Assumes a 100 MHz system clock and a 32-bit register bus.
*/
package tmcm_pkg;

  // Register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_TGT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STS = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_CHAN_EN = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_DIAG_BIT = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_DIAG_INP = 8'h2C;
  localparam logic [ADDR_W-1:0] OFF_DIAG_INT = 8'h30;

  // Command codes
  localparam logic [31:0] CMD_IDLE = 32'h0000_0000;
  localparam logic [31:0] CMD_RESET = 32'h0000_0001;

  // Response codes
  localparam logic [31:0] RESP_IDLE = 32'h0000_0000;
  localparam logic [31:0] RESP_BUSY = 32'h0000_0001;
  localparam logic [31:0] RESP_DONE = 32'h0000_0002;
  localparam logic [31:0] RESP_TIMEOUT = 32'h1111_1111;
  localparam logic [31:0] RESP_RSP_ERR = 32'h1111_1110;
  localparam logic [31:0] RESP_BIT_FAIL = 32'h1111_1101;
  localparam logic [31:0] RESP_INP_FAIL = 32'h1111_1100;
  localparam logic [31:0] RESP_ORDER = 32'h1111_0111;

  // Channel field and link operations
  localparam int CHAN_W = 4;
  localparam int NUM_CHAN = 15;
  localparam logic [CHAN_W-1:0] CHAN_BCAST = 4'hF;
  localparam logic [CHAN_W-1:0] CHAN_LAST = 4'hE;
  localparam logic [NUM_CHAN-1:0] CHAN_EN_RST = 15'h7FFF;
  localparam logic OP_RESET = 1'b0;
  localparam logic OP_DIAG = 1'b1;

  // Interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;

  // Reply timeout
  localparam int CLK_MHZ = 100;
  localparam int REPLY_TIMEOUT_US = 1000;
  localparam int REPLY_TIMEOUT_CYC = REPLY_TIMEOUT_US * CLK_MHZ;

  typedef enum logic [2:0] {
    S_IDLE, S_RST_TX, S_RST_WAIT, S_SCAN, S_DIAG_TX, S_DIAG_WAIT, S_HOLD
  } tmcm_state_t;

endpackage

// ### logic/tmcm_reply_eval.sv
/*
  Classifies one diagnostic reply into a mailbox response code.
  Assumes the reply flags are valid in the cycle the reply is offered.
*/
module tmcm_reply_eval
  import tmcm_pkg::*;
(
  input wire logic parity_err,
  input wire logic addr_err,
  input wire logic code_err,
  input wire logic bit_fail,
  input wire logic invalid_input,
  output logic [31:0] code,
  output logic is_err
);
  // Link faults first: a corrupted reply says nothing about the sensor
  always_comb begin
    if (parity_err || addr_err || code_err) begin
      code = RESP_RSP_ERR;
    end else if (bit_fail) begin
      code = RESP_BIT_FAIL;
    end else if (invalid_input) begin
      code = RESP_INP_FAIL;
    end else begin
      code = RESP_DONE;
    end
    is_err = code != RESP_DONE;
  end
endmodule // tmcm_reply_eval

// ### logic/tmcm_timeout.sv
/*
  Reply timeout counter: restarts on every transmitted request, stops
  when a reply arrives, pulses expired once the limit is reached.
  Assumes start and stop are single-cycle pulses on clk_sys.
*/
module tmcm_timeout
  import tmcm_pkg::*;
#(
  parameter int LIMIT = REPLY_TIMEOUT_CYC
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic stop,
  output logic expired
);
  localparam int CNT_W = $clog2(LIMIT + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(LIMIT - 1);

  logic [CNT_W-1:0] cnt_r;
  logic run_r;

  // Count while armed; a fresh start always wins over a stale run
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= run_r && !stop && !start && cnt_r == CNT_LAST;
      if (start) begin
        cnt_r <= '0;
        run_r <= 1'b1;
      end else if (stop || (run_r && cnt_r == CNT_LAST)) begin
        run_r <= 1'b0;
      end else if (run_r) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule // tmcm_timeout

// ### sim/tmcm_mailbox_bench.sv
/*
  Self-checking bench for the mailbox: AHB-Lite master tasks and command scenarios.
  Assumes a zero-wait slave and the link model in tmcm_xdcr_model.
*/
module tmcm_mailbox_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tmcm_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout, hresp, irq, req_valid, req_ready, req_op, rsp_valid;
  logic [31:0] hrdata, rd_smp, v;
  logic [CHAN_W-1:0] req_chan;
  logic [5:0] rsp_flags;
  logic silent = 1'b0;
  logic [5:0] err_flags = 6'h00;
  logic [7:0] dly = 8'h03;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  // Internal-failure case last, so its latch is still set after the loop
  logic [5:0] flag_tab[8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h18, 6'h00, 6'h20};
  logic [31:0] code_tab[8] = '{RESP_RSP_ERR, RESP_RSP_ERR, RESP_RSP_ERR, RESP_BIT_FAIL,
                               RESP_INP_FAIL, RESP_BIT_FAIL, RESP_DONE, RESP_DONE};

  tmcm_mailbox #(.TIMEOUT_CYC(40)) dut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .xdcr_req_valid(req_valid),
    .xdcr_req_ready(req_ready), .xdcr_req_op(req_op), .xdcr_req_chan(req_chan),
    .xdcr_rsp_valid(rsp_valid), .xdcr_rsp_parity_err(rsp_flags[0]), .xdcr_rsp_addr_err(rsp_flags[1]),
    .xdcr_rsp_code_err(rsp_flags[2]), .xdcr_rsp_bit_fail(rsp_flags[3]),
    .xdcr_rsp_invalid_input(rsp_flags[4]), .xdcr_rsp_internal_fail(rsp_flags[5]));
  tmcm_xdcr_model m (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_chan(req_chan), .rsp_valid(rsp_valid), .rsp_flags(rsp_flags),
    .silent(silent), .err_flags(err_flags), .dly(dly));

  // 100 MHz clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // Read data captured at the edge that ends the data phase
  always @(posedge clk_sys) begin
    rd_smp <= hrdata;
  end
  // Hang guard, far above the several hundred cycles the scenarios need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One single transfer; address held until hready, then data phase until hready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    #1;
    q = rd_smp;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask
  // Full command: start, see busy, wait for result, back to idle
  task automatic run(input logic [31:0] tgt, input logic [14:0] en, output logic [31:0] res);
    int n;
    m.log_q.delete();
    wr(OFF_CHAN_EN, {17'h00000, en});
    wr(OFF_TGT, tgt);
    wr(OFF_CMD, CMD_RESET);
    rd(OFF_CMD, res);
    chk("resp_busy", RESP_BUSY, res);
    for (n = 0; n < 300 && res === RESP_BUSY; n++) rd(OFF_CMD, res);
    wr(OFF_CMD, CMD_IDLE);
    rd(OFF_CMD, v);
    chk("resp_idle", RESP_IDLE, v);
  endtask
  task automatic chk_log(input logic [4:0] e0, input logic [4:0] e1, input logic [4:0] e2);
    chk("log_size", 32'h3, m.log_q.size());
    if (m.log_q.size() == 3) begin
      chk("log0", {27'h0, e0}, {27'h0, m.log_q[0]});
      chk("log1", {27'h0, e1}, {27'h0, m.log_q[1]});
      chk("log2", {27'h0, e2}, {27'h0, m.log_q[2]});
    end
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset values and reserved words
    rd(OFF_CMD, v);
    chk("resp_rst", RESP_IDLE, v);
    rd(OFF_TGT, v);
    chk("tgt_rst", 32'h0, v);
    rd(OFF_CHAN_EN, v);
    chk("chan_en_rst", {17'h0, CHAN_EN_RST}, v);
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    wr(8'h08, 32'hFFFF_FFFF);
    rd(8'h08, v);
    chk("reserved", 32'h0, v);
    // Reserved command code is ignored while idle
    wr(OFF_CMD, 32'h0000_0002);
    rd(OFF_CMD, v);
    chk("resp_rsvd", RESP_IDLE, v);
    wr(OFF_CMD, CMD_IDLE);
    // Unicast reset, then diagnostics of channels 0 and 2
    run(32'h3, 15'h0005, v);
    chk("unicast", RESP_DONE, v);
    chk_log({OP_RESET, 4'h3}, {OP_DIAG, 4'h0}, {OP_DIAG, 4'h2});
    // Broadcast; bit 4 of the address is not part of the channel
    run(32'h1F, 15'h0003, v);
    chk("bcast", RESP_DONE, v);
    chk_log({OP_RESET, CHAN_BCAST}, {OP_DIAG, 4'h0}, {OP_DIAG, 4'h1});
    // Every reply fault kind; reset reply carries the same flags but never errors
    for (int i = 0; i < 8; i++) begin
      err_flags <= flag_tab[i];
      run(32'h0, 15'h0001, v);
      chk("reply_code", code_tab[i], v);
      rd(OFF_DIAG_BIT, v);
      chk("diag_bit", {31'h0, flag_tab[i][3]}, v);
      rd(OFF_DIAG_INP, v);
      chk("diag_inp", {31'h0, flag_tab[i][4]}, v);
    end
    rd(OFF_DIAG_INT, v);
    chk("diag_int", 32'h1, v & 32'h1);
    err_flags <= 6'h00;
    // Silent transducer gives the timeout code
    silent <= 1'b1;
    run(32'h0, 15'h0001, v);
    chk("timeout", RESP_TIMEOUT, v);
    silent <= 1'b0;
    // Interrupt: set, masked, enabled, cleared
    rd(OFF_IRQ_STS, v);
    chk("irq_err", 32'h3, v);
    wr(OFF_IRQ_CLR, 32'h3);
    wr(OFF_IRQ_EN, 32'h0);
    run(32'h0, 15'h0001, v);
    rd(OFF_IRQ_STS, v);
    chk("irq_sts", 32'h1, v);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(OFF_IRQ_EN, 32'h1);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(OFF_IRQ_CLR, 32'h1);
    rd(OFF_IRQ_STS, v);
    chk("irq_clr", 32'h0, v);
    chk("irq_off", 32'h0, {31'h0, irq});
    // Slow reply: address change while busy, then a second command too early
    dly <= 8'd25;
    wr(OFF_CMD, CMD_RESET);
    rd(OFF_CMD, v);
    chk("busy_slow", RESP_BUSY, v);
    wr(OFF_TGT, 32'h9);
    rd(OFF_TGT, v);
    chk("tgt_run", 32'h9, v & 32'hF);
    wr(OFF_CMD, CMD_RESET);
    rd(OFF_CMD, v);
    chk("order", RESP_ORDER, v);
    wr(OFF_CMD, CMD_IDLE);
    rd(OFF_CMD, v);
    chk("order_idle", RESP_IDLE, v);
    summarize();
  end
endmodule // tmcm_mailbox_bench

// ### sim/tmcm_xdcr_model.sv
/*
  Behavioural link engine standing in for the serial transducers.
  Assumes the mailbox holds each request until ready and keeps one outstanding.
*/
module tmcm_xdcr_model
  import tmcm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_op,
  input wire logic [CHAN_W-1:0] req_chan,
  output logic rsp_valid,
  output logic [5:0] rsp_flags,
  input wire logic silent,
  input wire logic [5:0] err_flags,
  input wire logic [7:0] dly
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pend_r;
  logic [7:0] cnt_r;
  logic [4:0] log_q[$];
  // Accept only while idle, so a second request would be stalled
  assign req_ready = req_valid && !pend_r;
  // Reply dly+1 cycles after acceptance; flags toggle outside the pulse so stale values never read valid
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend_r <= 1'b0;
      cnt_r <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_flags <= 6'h00;
    end else begin
      rsp_valid <= 1'b0;
      rsp_flags <= ~rsp_flags;
      if (req_valid && req_ready) begin
        log_q.push_back({req_op, req_chan});
        pend_r <= 1'b1;
        cnt_r <= dly;
      end else if (pend_r && cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end else if (pend_r) begin
        pend_r <= 1'b0;
        rsp_valid <= !silent;
        rsp_flags <= err_flags;
      end
    end
  end
endmodule // tmcm_xdcr_model
